//--- core/d2rb_pkg.sv
// Shared constants and carrier types for the DDR2 refresh and burst access block.
// Assumes a 200 MHz core clock that samples every memory pin but the strobe input, the link clock among them.
package d2rb_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 5;
   // Refresh cycle time; the value is a plain default
   localparam int TRFC_NS = 195;
   localparam int TRFC_CYC = (TRFC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RFC_W = 8;

   // ----------------------------------------
   // Widths and depths
   // ----------------------------------------
   localparam int COL_W = 10;
   localparam int BANK_W = 3;
   localparam int ADDR_W = 13;
   localparam int DQ_W = 16;
   localparam int PIPE_D = 16;
   localparam int FIFO_D = 32;
   localparam int LAT_W = 4;

   // ----------------------------------------
   // Mode register fields
   // ----------------------------------------
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int EMR_AL_LSB = 3;
   localparam logic [2:0] BL4_CODE = 3'h2;
   localparam logic [2:0] BL8_CODE = 3'h3;
   localparam logic [2:0] CL_MIN = 3'h3;
   localparam logic [2:0] CL_MAX = 3'h6;
   localparam logic [2:0] AL_MAX = 3'h6;
   localparam logic [2:0] BA_MR = 3'h0;
   localparam logic [2:0] BA_EMR1 = 3'h1;
   localparam logic [2:0] LAST_BL4 = 3'h3;
   localparam logic [2:0] LAST_BL8 = 3'h7;

   // Command code is {ras_n, cas_n, we_n} with chip select low
   typedef enum logic [2:0] {
      OP_MRS = 3'h0,
      OP_REF = 3'h1,
      OP_PRE = 3'h2,
      OP_ACT = 3'h3,
      OP_WR = 3'h4,
      OP_RD = 3'h5,
      OP_RSV = 3'h6,
      OP_NOP = 3'h7
   } d2rb_op_t;

   typedef struct packed {
      logic ck;
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BANK_W-1:0] ba;
      logic [ADDR_W-1:0] a;
      logic [DQ_W-1:0] dq;
   } d2rb_pins_t;

   typedef struct packed {
      logic v;
      logic rd;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] col;
   } d2rb_cmd_t;

   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] col;
      logic [DQ_W-1:0] data;
   } d2rb_wbeat_t;

   typedef struct packed {
      logic [2:0] cl;
      logic [2:0] al;
      logic bl8;
      logic ilv;
   } d2rb_mode_t;

   localparam d2rb_mode_t MODE_RST = '{cl: CL_MIN, al: 3'h0, bl8: 1'b0, ilv: 1'b0};

   // Column of one beat inside the aligned group
   function automatic logic [COL_W-1:0] d2rb_beat_col(input logic [COL_W-1:0] col,
                                                     input logic [2:0] beat,
                                                     input logic bl8,
                                                     input logic ilv);
      logic [2:0] lo;
      lo = col[2:0];
      if (bl8) begin
         lo = ilv ? (col[2:0] ^ beat) : {col[2] ^ beat[2], 2'(col[1:0] + beat[1:0])};
      end else begin
         lo = {col[2], ilv ? (col[1:0] ^ beat[1:0]) : 2'(col[1:0] + beat[1:0])};
      end
      return {col[COL_W-1:3], lo};
   endfunction

endpackage

//--- core/d2rb_top.sv
// DDR2 device side: command decode, refresh, posted CAS and burst engine, write FIFO.
// Assumes every pin, the link clock too, is asynchronous to ref_clk_i and far slower.
//
// What this block does
// - Refresh ignores bank and address inputs; row address is internal.
// - Finished refresh leaves all banks precharged and idle.
// - Chip select low with RAS, CAS, WE high does nothing.
// - Chip select high ignores command and address inputs.
// - Bursts stay inside their aligned group of four or eight columns.
// - Reads and writes accepted any time, executed AL clocks later.
// - Read latency is AL plus CL; write latency is one less.
// - Only lengths 4 and 8; mode bits 2:0 length, bit 3 type.
// - Length 4 order: sequential wraps mod four, interleaved XORs beat.
// - Length 8: sequential wraps inside nibble, interleaved XORs three bits.
// - No burst stop; bursts end on completion or when a new burst of either type starts.
// - First read beat appears read-latency clocks after the command.
// - Strobe low one clock before data; beats on successive strobe edges.
// - CAS latency from mode register, additive latency from extended register.
// - Back-to-back bursts of one type run with no gap.
// - Additive latency 0 through 6 supported.

`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Write beat FIFO
// ----------------------------------------
module d2rb_fifo #(
   parameter int W = 29,
   parameter int DEPTH = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } d2rb_fifo_st_t;

   d2rb_fifo_st_t q;
   d2rb_fifo_st_t n;
   logic push;
   logic pop;

   assign in_ready_o = q.cnt != (AW + 1)'(DEPTH);
   assign out_valid_o = q.cnt != '0;
   assign out_data_o = q.mem[q.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb begin
      n = q;
      if (push) begin
         n.mem[q.wp] = in_data_i;
         n.wp = AW'(q.wp + 1'b1);
      end
      if (pop) begin
         n.rp = AW'(q.rp + 1'b1);
      end
      if (push & ~pop) begin
         n.cnt = (AW + 1)'(q.cnt + 1'b1);
      end else if (pop & ~push) begin
         n.cnt = (AW + 1)'(q.cnt - 1'b1);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

// ----------------------------------------
// Device top
// ----------------------------------------
module d2rb_top (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ck_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [d2rb_pkg::BANK_W-1:0] ba_i,
   input wire logic [d2rb_pkg::ADDR_W-1:0] a_i,
   input wire logic [d2rb_pkg::DQ_W-1:0] dq_i,
   output logic [d2rb_pkg::DQ_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic dqs_i,
   output logic dqs_o,
   output logic dqs_oe_o,
   output logic [d2rb_pkg::BANK_W-1:0] rd_bank_o,
   output logic [d2rb_pkg::COL_W-1:0] rd_col_o,
   input wire logic [d2rb_pkg::DQ_W-1:0] rd_data_i,
   output logic wbeat_valid_o,
   input wire logic wbeat_ready_i,
   output d2rb_pkg::d2rb_wbeat_t wbeat_o,
   output logic refresh_pulse_o,
   output logic refresh_busy_o,
   output logic banks_idle_o,
   output d2rb_pkg::d2rb_mode_t mode_o,
   output logic wr_drop_o
);
   import d2rb_pkg::*;

   typedef struct packed {
      d2rb_pins_t s1;
      d2rb_pins_t s2;
      logic ck_d;
      d2rb_mode_t mode;
      d2rb_cmd_t [PIPE_D-1:0] pipe;
      d2rb_cmd_t bst;
      logic bl8;
      logic ilv;
      logic act;
      logic [2:0] beat;
      logic [BANK_W-1:0] rbank;
      logic [COL_W-1:0] rcol;
      logic load;
      logic [DQ_W-1:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_oe;
      logic [RFC_W-1:0] rfc;
      logic ref_pulse;
      logic idle;
      logic drop;
   } d2rb_st_t;

   d2rb_st_t q;
   d2rb_st_t n;
   d2rb_pins_t pins;
   logic rise;
   logic fall;
   logic sel;
   d2rb_op_t op;
   logic [LAT_W-1:0] rl;
   logic [LAT_W-1:0] wl;
   logic start;
   logic push_valid;
   logic push_ready;
   d2rb_wbeat_t push_data;

   // All pins but the strobe input, the link clock included, pass through both synchroniser stages before use
   assign pins = '{ck: ck_i, cke: cke_i, cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i,
                   we_n: we_n_i, ba: ba_i, a: a_i, dq: dq_i};

   // ----------------------------------------
   // Edge detect and command decode
   // ----------------------------------------
   assign rise = q.s2.ck & ~q.ck_d;
   assign fall = ~q.s2.ck & q.ck_d;
   assign sel = rise & q.s2.cke & ~q.s2.cs_n;
   assign op = d2rb_op_t'({q.s2.ras_n, q.s2.cas_n, q.s2.we_n});
   assign rl = LAT_W'(q.mode.al) + LAT_W'(q.mode.cl);
   assign wl = LAT_W'(rl - 1'b1);
   assign start = rise & q.pipe[0].v;

   always_comb begin
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      n.ck_d = q.s2.ck;
      n.ref_pulse = 1'b0;
      n.load = 1'b0;
      push_valid = 1'b0;
      push_data = '0;

      // ----------------------------------------
      // Refresh timer
      // ----------------------------------------
      if (q.rfc != '0) begin
         n.rfc = RFC_W'(q.rfc - 1'b1);
         if (q.rfc == RFC_W'(1)) begin
            n.idle = 1'b1;
         end
      end

      // ----------------------------------------
      // Posted column pipe, one slot per link clock
      // ----------------------------------------
      if (rise) begin
         for (int i = 0; i < PIPE_D - 1; i++) begin
            n.pipe[i] = q.pipe[i+1];
         end
         n.pipe[PIPE_D-1] = '0;
      end

      // NOP, deselect and unknown codes fall through untouched
      if (sel) begin
         unique case (op)
            OP_MRS: begin
               if (q.s2.ba == BA_MR) begin
                  // Unsupported lengths keep the old setting
                  if (q.s2.a[MR_BL_LSB+:3] == BL4_CODE || q.s2.a[MR_BL_LSB+:3] == BL8_CODE) begin
                     n.mode.bl8 = q.s2.a[MR_BL_LSB+:3] == BL8_CODE;
                  end
                  n.mode.ilv = q.s2.a[MR_BT_BIT];
                  if (q.s2.a[MR_CL_LSB+:3] >= CL_MIN && q.s2.a[MR_CL_LSB+:3] <= CL_MAX) begin
                     n.mode.cl = q.s2.a[MR_CL_LSB+:3];
                  end
               end else if (q.s2.ba == BA_EMR1) begin
                  if (q.s2.a[EMR_AL_LSB+:3] <= AL_MAX) begin
                     n.mode.al = q.s2.a[EMR_AL_LSB+:3];
                  end
               end
            end
            OP_REF: begin
               // Bank and address are never looked at here
               n.rfc = RFC_W'(TRFC_CYC);
               n.ref_pulse = 1'b1;
            end
            OP_ACT: begin
               n.idle = 1'b0;
            end
            OP_RD: begin
               n.pipe[rl-1'b1] = '{v: 1'b1, rd: 1'b1, bank: q.s2.ba, col: q.s2.a[COL_W-1:0]};
            end
            OP_WR: begin
               n.pipe[wl-1'b1] = '{v: 1'b1, rd: 1'b0, bank: q.s2.ba, col: q.s2.a[COL_W-1:0]};
            end
            OP_PRE, OP_RSV, OP_NOP: begin
            end
         endcase
      end

      // ----------------------------------------
      // Burst engine, one beat per link edge
      // ----------------------------------------
      if (start) begin
         // A fresh start also cuts an eight beat burst short, and follows a finished one
         // on the very same edge, so no gap opens between bursts
         n.bst = q.pipe[0];
         n.bl8 = q.mode.bl8;
         n.ilv = q.mode.ilv;
         n.act = 1'b1;
         n.beat = 3'h0;
      end else if ((rise | fall) & q.act) begin
         // Without a new start, only completion ends a burst
         if (q.beat == (q.bl8 ? LAST_BL8 : LAST_BL4)) begin
            n.act = 1'b0;
         end else begin
            n.beat = 3'(q.beat + 1'b1);
         end
      end

      if ((rise | fall) & n.act) begin
         if (n.bst.rd) begin
            n.rbank = n.bst.bank;
            n.rcol = d2rb_beat_col(n.bst.col, n.beat, n.bl8, n.ilv);
            n.load = 1'b1;
         end else begin
            push_valid = 1'b1;
            push_data = '{bank: n.bst.bank,
                          col: d2rb_beat_col(n.bst.col, n.beat, n.bl8, n.ilv),
                          data: q.s2.dq};
         end
      end

      // Beats that find the FIFO full are lost; the flag tells software
      if (push_valid & ~push_ready) begin
         n.drop = 1'b1;
      end

      // ----------------------------------------
      // Read data and strobe outputs
      // ----------------------------------------
      if (q.load) begin
         n.dq = rd_data_i;
      end
      n.dq_oe = n.act & n.bst.rd;
      // Preamble holds the strobe low for the clock before the first beat
      n.dqs_oe = (n.act & n.bst.rd) | (n.pipe[0].v & n.pipe[0].rd);
      n.dqs = n.act & n.bst.rd & q.ck_d;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.mode <= MODE_RST;
         q.idle <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------
   // Write beat buffer
   // ----------------------------------------
   d2rb_fifo #(
      .W($bits(d2rb_wbeat_t)),
      .DEPTH(FIFO_D)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(push_data),
      .out_valid_o(wbeat_valid_o),
      .out_ready_i(wbeat_ready_i),
      .out_data_o(wbeat_o)
   );

   assign dq_o = q.dq;
   assign dq_oe_o = q.dq_oe;
   assign dqs_o = q.dqs;
   assign dqs_oe_o = q.dqs_oe;
   assign rd_bank_o = q.rbank;
   assign rd_col_o = q.rcol;
   assign refresh_pulse_o = q.ref_pulse;
   assign refresh_busy_o = q.rfc != '0;
   assign banks_idle_o = q.idle;
   assign mode_o = q.mode;
   assign wr_drop_o = q.drop;
endmodule

`default_nettype wire

//--- test/d2rb_ctrl_model.sv
// Controller model: free-running link clock, command pins and write data.
// Assumes cmd is called from one bench process at a time.
`timescale 1ns/10ps
`default_nettype none
module d2rb_ctrl_model (
   output var d2rb_pkg::d2rb_pins_t pins_o,
   output int ecnt_o
);
   import d2rb_pkg::*;
   // ----------------------------------------
   // Link clock and write data
   // ----------------------------------------
   initial begin
      pins_o = '{ck: 1'b0, cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
         ba: 3'h0, a: 13'h0, dq: 16'h0};
      ecnt_o = 0;
      // Count moves first so a waiter sees the new edge index
      forever begin
         #80;
         ecnt_o = ecnt_o + 1;
         pins_o.ck = ~pins_o.ck;
      end
   end
   // Data changes mid-phase and holds the index of the edge that samples it
   always @(pins_o.ck) begin
      #40;
      pins_o.dq = 16'(ecnt_o + 1);
   end
   // ----------------------------------------
   // One command, then a no-op: two link clocks between commands
   // ----------------------------------------
   task automatic cmd(input d2rb_op_t op, input logic [2:0] b, input logic [12:0] ad,
      output int rise_e, input logic cs_n = 1'b0, input logic cke = 1'b1);
      @(negedge pins_o.ck);
      {pins_o.cke, pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = {cke, cs_n, op};
      {pins_o.ba, pins_o.a} = {b, ad};
      rise_e = ecnt_o + 1;
      @(negedge pins_o.ck);
      {pins_o.cke, pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = 5'h17;
      // Don't-care lines flip so a stale value cannot pass for a held one
      {pins_o.ba, pins_o.a} = ~{b, ad};
   endtask
endmodule
`default_nettype wire

//--- test/d2rb_asserts.sv
// Checker: refresh and read strobe relations at the device top ports.
// Assumes it is bound into d2rb_top and sees its clock, reset and outputs only.
`timescale 1ns/10ps
`default_nettype none
module d2rb_asserts (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic dq_oe_o,
   input wire logic dqs_o,
   input wire logic dqs_oe_o,
   input wire logic refresh_pulse_o,
   input wire logic refresh_busy_o,
   input wire logic banks_idle_o,
   input wire d2rb_pkg::d2rb_mode_t mode_o
);
   import d2rb_pkg::*;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Cycles since the last refresh pulse
   // ----------------------------------------
   always_comb begin
      cnt_nxt = refresh_pulse_o ? 8'h1 : cnt_r + 8'h1;
   end
   always_ff @(posedge ref_clk_i) begin
      cnt_r <= rst_i ? 8'h0 : cnt_nxt;
   end
   sequence s_busy_start;
      refresh_busy_o ##1 refresh_busy_o[*8];
   endsequence
   sequence s_preamble;
      (!dqs_o && !dq_oe_o)[*4];
   endsequence
   a_pulse_single: assert property (refresh_pulse_o |=> !refresh_pulse_o)
      else $error("refresh pulse too long");
   a_pulse_busy: assert property ($rose(refresh_pulse_o) |-> s_busy_start)
      else $error("busy missing after refresh");
   a_busy_length: assert property ($fell(refresh_busy_o) |-> cnt_r == 8'(TRFC_CYC))
      else $error("busy length wrong");
   a_idle_after: assert property ($fell(refresh_busy_o) |-> banks_idle_o)
      else $error("banks not idle after refresh");
   a_dq_strobe: assert property (dq_oe_o |-> dqs_oe_o)
      else $error("data driven without strobe");
   a_read_preamble: assert property ($rose(dqs_oe_o) |-> s_preamble)
      else $error("strobe preamble wrong");
   a_oe_release: assert property ($fell(dq_oe_o) |-> $fell(dqs_oe_o))
      else $error("strobe outlives data");
   a_mode_legal: assert property (mode_o.al <= AL_MAX &&
      mode_o.cl >= CL_MIN && mode_o.cl <= CL_MAX) else $error("mode out of range");
endmodule
bind d2rb_top d2rb_asserts chk (.*);
`default_nettype wire

//--- test/d2rb_top_bench.sv
// Bench: drives the device through the controller model and checks its outputs.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module d2rb_top_bench;
   import d2rb_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wbeat_ready_i = 1'b1;
   logic [DQ_W-1:0] dq_o;
   logic [BANK_W-1:0] rd_bank_o;
   logic [COL_W-1:0] rd_col_o;
   logic dq_oe_o, dqs_o, dqs_oe_o, wbeat_valid_o, wr_drop_o;
   logic refresh_pulse_o, refresh_busy_o, banks_idle_o;
   d2rb_wbeat_t wbeat_o;
   d2rb_mode_t mode_o;
   d2rb_pins_t pins;
   int ecnt, fails = 0, checked = 0, npulse = 0, cycles = 0;
   logic [DQ_W-1:0] dq_q[$];
   int e_q[$];
   d2rb_wbeat_t w_q[$];
   d2rb_mode_t cfg[4] = '{'{3'h3, 3'h0, 1'b0, 1'b0}, '{3'h4, 3'h2, 1'b0, 1'b1},
      '{3'h5, 3'h6, 1'b1, 1'b0}, '{3'h6, 3'h1, 1'b1, 1'b1}};
   wire logic [DQ_W-1:0] rd_data = {rd_bank_o, 3'h0, rd_col_o};
   d2rb_ctrl_model ctl (.pins_o(pins), .ecnt_o(ecnt));
   d2rb_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ck_i(pins.ck), .cke_i(pins.cke),
      .cs_n_i(pins.cs_n), .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n), .we_n_i(pins.we_n),
      .ba_i(pins.ba), .a_i(pins.a), .dq_i(pins.dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
      .dqs_i(1'b0), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o), .rd_bank_o(rd_bank_o),
      .rd_col_o(rd_col_o),
      .rd_data_i(rd_data), .wbeat_valid_o(wbeat_valid_o), .wbeat_ready_i(wbeat_ready_i),
      .wbeat_o(wbeat_o), .refresh_pulse_o(refresh_pulse_o), .refresh_busy_o(refresh_busy_o),
      .banks_idle_o(banks_idle_o), .mode_o(mode_o), .wr_drop_o(wr_drop_o));
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // ----------------------------------------
   // Monitors and timeout
   // ----------------------------------------
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (refresh_pulse_o === 1'b1) npulse <= npulse + 1;
      if (wbeat_valid_o === 1'b1 && wbeat_ready_i === 1'b1) w_q.push_back(wbeat_o);
      if (cycles == 40000) begin
         fails++;
         summarize();
      end
   end
   // Mid-phase sample, well after the synchroniser delay
   always @(pins.ck) begin : cap
      int e;
      e = ecnt;
      #40;
      if (dq_oe_o === 1'b1) begin
         dq_q.push_back(dq_o);
         e_q.push_back(e);
         // Strobe follows the link clock level under each beat
         chk(dqs_o, pins.ck);
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [9:0] ecol(logic [9:0] c, int i, logic b8, logic il);
      logic [2:0] k;
      k = 3'(i);
      if (il) k = b8 ? c[2:0] ^ k : {c[2], c[1:0] ^ k[1:0]};
      else k = {b8 ? c[2] ^ k[2] : c[2], 2'(c[1:0] + k[1:0])};
      return {c[9:3], k};
   endfunction
   task automatic set_mode(input d2rb_mode_t m);
      int ce;
      ctl.cmd(OP_MRS, BA_MR, 13'({m.cl, m.ilv, m.bl8 ? BL8_CODE : BL4_CODE}), ce);
      ctl.cmd(OP_MRS, BA_EMR1, 13'({m.al, 3'h0}), ce);
   endtask
   // Two bursts two clocks apart; the first yields four beats in either length
   task automatic access(input logic rd, input d2rb_mode_t m, input logic [2:0] b,
      input logic [9:0] c);
      int ce, rl, nb, k;
      logic [9:0] col;
      dq_q.delete();
      w_q.delete();
      e_q.delete();
      rl = m.al + m.cl;
      ctl.cmd(rd ? OP_RD : OP_WR, b, {3'h0, c}, ce);
      ctl.cmd(rd ? OP_RD : OP_WR, b, {3'h0, c ^ 10'h3f8}, k);
      repeat (24) @(negedge pins.ck);
      nb = m.bl8 ? 12 : 8;
      chk(rd ? dq_q.size() : w_q.size(), nb);
      for (k = 0; k < nb; k++) begin
         col = k < 4 ? ecol(c, k, m.bl8, m.ilv) : ecol(c ^ 10'h3f8, k - 4, m.bl8, m.ilv);
         if (rd) begin
            chk(dq_q[k], {b, 3'h0, col});
            chk(e_q[k], ce + 2 * rl + k);
         end else begin
            chk(w_q[k], {b, col, 16'(ce + 2 * rl - 2 + k)});
         end
      end
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      int ce;
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk(mode_o, MODE_RST);
      chk(banks_idle_o, 1'b1);
      ctl.cmd(OP_REF, 3'h7, 13'h1fff, ce, 1'b1);
      ctl.cmd(OP_MRS, BA_MR, 13'h005b, ce, 1'b1);
      ctl.cmd(OP_REF, 3'h7, 13'h1fff, ce, 1'b0, 1'b0);
      ctl.cmd(OP_NOP, 3'h0, 13'h0, ce);
      chk(npulse, 0);
      chk(mode_o, MODE_RST);
      ctl.cmd(OP_ACT, 3'h2, 13'h0123, ce);
      chk(banks_idle_o, 1'b0);
      ctl.cmd(OP_REF, 3'h5, 13'h1abc, ce);
      repeat (60) @(negedge ref_clk_i);
      chk(npulse, 1);
      chk(banks_idle_o, 1'b1);
      foreach (cfg[i]) begin
         set_mode(cfg[i]);
         chk(mode_o, cfg[i]);
         access(1'b1, cfg[i], 3'(i), 10'h2c5 + 10'(i));
         access(1'b0, cfg[i], 3'(i + 4), 10'h13a - 10'(i));
      end
      ctl.cmd(OP_MRS, BA_MR, 13'h079, ce);
      ctl.cmd(OP_MRS, BA_EMR1, 13'h038, ce);
      chk(mode_o, cfg[3]);
      // Stalled drain: forty beats against thirty-two places
      wbeat_ready_i = 1'b0;
      for (int j = 0; j < 5; j++) begin
         ctl.cmd(OP_WR, 3'h1, 13'h040, ce);
         ctl.cmd(OP_NOP, 3'h0, 13'h0, ce);
      end
      repeat (24) @(negedge pins.ck);
      chk(wr_drop_o, 1'b1);
      w_q.delete();
      wbeat_ready_i = 1'b1;
      repeat (60) @(negedge ref_clk_i);
      chk(w_q.size() >= 32 && w_q.size() <= 34, 1'b1);
      chk(wbeat_valid_o, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
